// ---- shared/clock_guard_cfg.svh ----
// offsets, field positions, reset values and counts of the clock-loss guard
`ifndef CLOCK_GUARD_CFG_SVH
`define CLOCK_GUARD_CFG_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define OFS_PROCESSOR_MODE_A 8'h04
`define OFS_PROCESSOR_MODE_B 8'h05
`define OFS_SYS_CLOCK_CTRL_A 8'h06
`define OFS_SYS_CLOCK_CTRL_B 8'h07
`define OFS_SYS_CLOCK_CTRL_C 8'h08
`define OFS_WRITE_PROTECT 8'h0A
`define OFS_CLOCK_LOSS_DETECT 8'h0C
`define OFS_REFERENCE_CONTROL 8'h15
`define OFS_ONCHIP_OSC_CTRL_BASE 8'h23
`define NUM_ONCHIP_OSC_CTRL 4
`define OFS_VOLTAGE_DETECT_CTRL 8'h31
`define OFS_DETECT_LEVEL_SELECT 8'h32
`define OFS_MONITOR0_CTRL 8'h38
`define OFS_MONITOR1_CTRL 8'h39
`define OFS_MONITOR2_CTRL 8'h3A

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define BIT_PROTECT_CLOCK 0
`define BIT_PROTECT_PMODE 1
`define BIT_PROTECT_VOLTAGE 3
`define PROTECT_WRITABLE_MASK 8'h7F
`define BIT_FALLBACK_SELECT 2
`define BIT_CRYSTAL_STOPPED 3
`define DETECT_ARMED_CODE 2'h3
`define BIT_PERIPH_STOP_WAIT 2
`define BIT_CRYSTAL_STOP 5
`define BIT_ALL_CLOCKS_STOP 0
`define BIT_LOW_SPEED_STOP 4
`define BIT_WAIT_REQUEST 0
`define BIT_HS_OSC_RUN 0
`define BIT_HS_SELECT 1
`define BIT_MON1_SOURCE 2
`define BIT_MON2_SOURCE 2
`define BIT_WDOG_SOURCE 3

// ------------------------------------------------------------
// reset values and counts
// ------------------------------------------------------------
`define RESET_BYTE 8'h00
`define DETECT_WINDOW_CYCLES 64
`define DETECT_COUNT_WIDTH 8

`endif

// ---- shared/clock_guard_pkg.sv ----
// types shared by the clock-loss guard
package clock_guard_pkg;
	typedef logic [7:0] reg_byte_t;
	typedef enum logic [1:0]
	{
		DET_IDLE,
		DET_WATCH,
		DET_STOPPED
	} detect_state_t;
endpackage : clock_guard_pkg

// ---- core/main_clock_loss_detect_guard.sv ----
// main crystal loss detection, shared-vector source flags and write protection
// What the document asks of this block and of its software
// [R1] arm detection only when field equals 11b
// [R2] on loss: fallback, stopped flag, low-speed on, interrupt
// [R3] software disarms below 2 MHz crystal
// [R4] clock loss shares vector with watchdog, monitors
// [R5] source shown by stopped flag, or armed+fallback
// [R6] watchdog and monitor sources have own flags
// [R7] software switches back to crystal itself
// [R8] software keeps peripheral clocks in wait
// [R9] software disarms before stopping crystal deliberately
// [R10] low-speed fallback: clear select, then arm
// [R11] high-speed fallback: run, select, then arm
// [R12] clear flash rewrite before all-clocks-stop
// [R13] prefetch four bytes; jump plus four no-ops
// [R14] clear flash rewrite, no-ops after wait request
// [R15] clock registers writable only with protect bit 0
// [R16] mode registers writable only with protect bit 1
// [R17] voltage registers writable only with protect bit 3
// [R18] protect bits never clear themselves
// [R19] reserved protect bits written zero; b7 reads zero
// [R20] sense loss by missing edges in window
`include "clock_guard_cfg.svh"

module main_clock_loss_detect_guard
#(
	parameter int DETECT_WINDOW = `DETECT_WINDOW_CYCLES,
	parameter int COUNT_WIDTH = `DETECT_COUNT_WIDTH
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic main_crystal_clock,
	input wire logic cpu_source_crystal,
	input wire logic watchdog_event,
	input wire logic monitor1_event,
	input wire logic monitor2_event,
	output logic shared_irq,
	output logic clock_loss_source,
	output logic fallback_to_onchip,
	output logic crystal_stopped,
	output logic low_speed_osc_stop,
	output logic periph_clock_stop_in_wait,
	output logic crystal_stop,
	output logic stop_mode_request,
	output logic wait_request,
	output logic high_speed_osc_run,
	output logic high_speed_select
);

	// ------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------
	clock_guard_pkg::reg_byte_t write_protect_control;
	clock_guard_pkg::reg_byte_t clock_loss_detect_reg;
	clock_guard_pkg::reg_byte_t sys_clock_ctrl_a;
	clock_guard_pkg::reg_byte_t sys_clock_ctrl_b;
	clock_guard_pkg::reg_byte_t sys_clock_ctrl_c;
	clock_guard_pkg::reg_byte_t onchip_osc_ctrl [0:`NUM_ONCHIP_OSC_CTRL-1];
	clock_guard_pkg::reg_byte_t processor_mode_a;
	clock_guard_pkg::reg_byte_t processor_mode_b;
	clock_guard_pkg::reg_byte_t reference_control;
	clock_guard_pkg::reg_byte_t voltage_detect_ctrl;
	clock_guard_pkg::reg_byte_t detect_level_select;
	clock_guard_pkg::reg_byte_t monitor0_ctrl;
	clock_guard_pkg::reg_byte_t monitor1_ctrl;
	clock_guard_pkg::reg_byte_t monitor2_ctrl;

	// ------------------------------------------------------------
	// detector state
	// ------------------------------------------------------------
	clock_guard_pkg::detect_state_t detect_state;
	clock_guard_pkg::detect_state_t next_detect_state;
	logic [COUNT_WIDTH-1:0] idle_count;
	logic crystal_sample;
	logic crystal_prev;
	logic crystal_edge;
	logic detect_armed;
	logic watch_enable;
	logic loss_event;
	logic window_expired;

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------

	// group of a register address: 1 clock, 2 mode, 3 voltage, 0 other
	function automatic logic [1:0] protect_group(input logic [7:0] addr);
		if (addr == `OFS_SYS_CLOCK_CTRL_A || addr == `OFS_SYS_CLOCK_CTRL_B
			|| addr == `OFS_SYS_CLOCK_CTRL_C || addr == `OFS_CLOCK_LOSS_DETECT
			|| (addr >= `OFS_ONCHIP_OSC_CTRL_BASE
			&& addr < `OFS_ONCHIP_OSC_CTRL_BASE + 8'(`NUM_ONCHIP_OSC_CTRL)))
			protect_group = 2'h1;
		else if (addr == `OFS_PROCESSOR_MODE_A || addr == `OFS_PROCESSOR_MODE_B)
			protect_group = 2'h2;
		else if (addr == `OFS_REFERENCE_CONTROL || addr == `OFS_VOLTAGE_DETECT_CTRL
			|| addr == `OFS_DETECT_LEVEL_SELECT || addr == `OFS_MONITOR0_CTRL
			|| addr == `OFS_MONITOR1_CTRL || addr == `OFS_MONITOR2_CTRL)
			protect_group = 2'h3;
		else
			protect_group = 2'h0;
	endfunction : protect_group

	// true when a write to addr passes the protect bits
	function automatic logic write_allowed(input logic [7:0] addr, input logic [7:0] prot);
		case (protect_group(addr))
			// [R15] clock group gate
			2'h1: write_allowed = prot[`BIT_PROTECT_CLOCK];
			// [R16] mode group gate
			2'h2: write_allowed = prot[`BIT_PROTECT_PMODE];
			// [R17] voltage group gate
			2'h3: write_allowed = prot[`BIT_PROTECT_VOLTAGE];
			default: write_allowed = 1'b1;
		endcase
	endfunction : write_allowed

	// one-cycle hit for an accepted write to one offset
	function automatic logic write_hit(input logic [7:0] target);
		write_hit = reg_write && reg_addr == target && write_allowed(reg_addr, write_protect_control);
	endfunction : write_hit

	// ------------------------------------------------------------
	// crystal edge sensing
	// ------------------------------------------------------------

	// crystal pin is taken as synchronous; two samples reveal any toggle
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			crystal_sample <= 1'b0;
			crystal_prev <= 1'b0;
		end
		else
		begin
			crystal_sample <= main_crystal_clock;
			crystal_prev <= crystal_sample;
		end
	end

	assign crystal_edge = crystal_sample != crystal_prev;
	// [R1] armed only on code 11b
	assign detect_armed = clock_loss_detect_reg[1:0] == `DETECT_ARMED_CODE;
	// watching makes sense only while the crystal really feeds the cpu
	assign watch_enable = detect_armed && cpu_source_crystal
		&& !clock_loss_detect_reg[`BIT_FALLBACK_SELECT];
	assign window_expired = idle_count >= COUNT_WIDTH'(DETECT_WINDOW - 1);

	// ------------------------------------------------------------
	// detector state machine
	// ------------------------------------------------------------

	// next state of the loss detector
	always_comb
	begin
		next_detect_state = detect_state;
		case (detect_state)
			clock_guard_pkg::DET_IDLE:
				if (watch_enable)
					next_detect_state = clock_guard_pkg::DET_WATCH;
			clock_guard_pkg::DET_WATCH:
				if (!watch_enable)
					next_detect_state = clock_guard_pkg::DET_IDLE;
				// [R20] no edge within window
				else if (!crystal_edge && window_expired)
					next_detect_state = clock_guard_pkg::DET_STOPPED;
			clock_guard_pkg::DET_STOPPED:
				if (crystal_edge)
					next_detect_state = clock_guard_pkg::DET_IDLE;
			default:
				next_detect_state = clock_guard_pkg::DET_IDLE;
		endcase
	end

	assign loss_event = detect_state == clock_guard_pkg::DET_WATCH
		&& next_detect_state == clock_guard_pkg::DET_STOPPED;

	// state register of the loss detector
	always_ff @(posedge clock)
	begin
		if (rst)
			detect_state <= clock_guard_pkg::DET_IDLE;
		else
			detect_state <= next_detect_state;
	end

	// cycles since last crystal edge; saturates so a long stop cannot wrap
	always_ff @(posedge clock)
	begin
		if (rst)
			idle_count <= '0;
		// [R20] restart window on edge
		else if (crystal_edge || detect_state != clock_guard_pkg::DET_WATCH)
			idle_count <= '0;
		else if (!window_expired)
			idle_count <= idle_count + 1'b1;
	end

	// ------------------------------------------------------------
	// protect register
	// ------------------------------------------------------------

	// only software changes it; protected writes leave it alone
	always_ff @(posedge clock)
	begin
		if (rst)
			write_protect_control <= `RESET_BYTE;
		// [R18] no self clearing
		else if (reg_write && reg_addr == `OFS_WRITE_PROTECT)
			// [R19] b7 never stored
			write_protect_control <= reg_wdata & `PROTECT_WRITABLE_MASK;
	end

	// ------------------------------------------------------------
	// clock-loss detect register
	// ------------------------------------------------------------

	// arm field and fallback flag are software's; hardware set wins a clash
	always_ff @(posedge clock)
	begin
		if (rst)
			clock_loss_detect_reg <= `RESET_BYTE;
		else
		begin
			if (write_hit(`OFS_CLOCK_LOSS_DETECT))
			begin
				clock_loss_detect_reg[1:0] <= reg_wdata[1:0];
				clock_loss_detect_reg[`BIT_FALLBACK_SELECT] <= reg_wdata[`BIT_FALLBACK_SELECT];
			end
			// [R2] fallback and stopped flags
			if (loss_event)
			begin
				clock_loss_detect_reg[`BIT_FALLBACK_SELECT] <= 1'b1;
				clock_loss_detect_reg[`BIT_CRYSTAL_STOPPED] <= 1'b1;
			end
			// stopped flag follows the crystal once edges return
			else if (detect_state == clock_guard_pkg::DET_STOPPED && crystal_edge)
				clock_loss_detect_reg[`BIT_CRYSTAL_STOPPED] <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// system clock control registers
	// ------------------------------------------------------------

	// plain stores, except the low-speed stop bit forced on a loss
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			sys_clock_ctrl_a <= `RESET_BYTE;
			sys_clock_ctrl_b <= `RESET_BYTE;
			sys_clock_ctrl_c <= `RESET_BYTE;
		end
		else
		begin
			if (write_hit(`OFS_SYS_CLOCK_CTRL_A))
				sys_clock_ctrl_a <= reg_wdata;
			if (write_hit(`OFS_SYS_CLOCK_CTRL_B))
				sys_clock_ctrl_b <= reg_wdata;
			// [R2] keep low-speed oscillator running
			if (loss_event)
				sys_clock_ctrl_b[`BIT_LOW_SPEED_STOP] <= 1'b0;
			if (write_hit(`OFS_SYS_CLOCK_CTRL_C))
				sys_clock_ctrl_c <= reg_wdata;
		end
	end

	// on-chip oscillator controls, indexed from the base offset
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			for (int i = 0; i < `NUM_ONCHIP_OSC_CTRL; i++)
				onchip_osc_ctrl[i] <= `RESET_BYTE;
		end
		else
		begin
			for (int i = 0; i < `NUM_ONCHIP_OSC_CTRL; i++)
				if (write_hit(`OFS_ONCHIP_OSC_CTRL_BASE + 8'(i)))
					onchip_osc_ctrl[i] <= reg_wdata;
		end
	end

	// ------------------------------------------------------------
	// processor mode and voltage registers
	// ------------------------------------------------------------

	// processor mode pair
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			processor_mode_a <= `RESET_BYTE;
			processor_mode_b <= `RESET_BYTE;
		end
		else
		begin
			if (write_hit(`OFS_PROCESSOR_MODE_A))
				processor_mode_a <= reg_wdata;
			if (write_hit(`OFS_PROCESSOR_MODE_B))
				processor_mode_b <= reg_wdata;
		end
	end

	// voltage-side plain stores
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			reference_control <= `RESET_BYTE;
			voltage_detect_ctrl <= `RESET_BYTE;
			detect_level_select <= `RESET_BYTE;
			monitor0_ctrl <= `RESET_BYTE;
		end
		else
		begin
			if (write_hit(`OFS_REFERENCE_CONTROL))
				reference_control <= reg_wdata;
			if (write_hit(`OFS_VOLTAGE_DETECT_CTRL))
				voltage_detect_ctrl <= reg_wdata;
			if (write_hit(`OFS_DETECT_LEVEL_SELECT))
				detect_level_select <= reg_wdata;
			if (write_hit(`OFS_MONITOR0_CTRL))
				monitor0_ctrl <= reg_wdata;
		end
	end

	// monitor 1 and 2 controls carry source flags; an event beats a clear
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			monitor1_ctrl <= `RESET_BYTE;
			monitor2_ctrl <= `RESET_BYTE;
		end
		else
		begin
			if (write_hit(`OFS_MONITOR1_CTRL))
				monitor1_ctrl <= reg_wdata;
			if (write_hit(`OFS_MONITOR2_CTRL))
				monitor2_ctrl <= reg_wdata;
			// [R6] per-source flags
			if (monitor1_event)
				monitor1_ctrl[`BIT_MON1_SOURCE] <= 1'b1;
			if (monitor2_event)
				monitor2_ctrl[`BIT_MON2_SOURCE] <= 1'b1;
			if (watchdog_event)
				monitor2_ctrl[`BIT_WDOG_SOURCE] <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// shared interrupt request
	// ------------------------------------------------------------

	// one pulse for all four sources; handler tells them apart by flags
	always_ff @(posedge clock)
	begin
		if (rst)
			shared_irq <= 1'b0;
		else
			// [R4] one vector request
			shared_irq <= loss_event || watchdog_event || monitor1_event || monitor2_event;
	end

	// [R5] clock-loss source indication
	assign clock_loss_source = clock_loss_detect_reg[`BIT_CRYSTAL_STOPPED]
		|| (detect_armed && clock_loss_detect_reg[`BIT_FALLBACK_SELECT]);

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------

	// data stand in the cycle after the strobe only; unmapped reads zero
	always_ff @(posedge clock)
	begin
		if (rst || !reg_read)
			reg_rdata <= `RESET_BYTE;
		else if (reg_addr == `OFS_WRITE_PROTECT)
			reg_rdata <= write_protect_control;
		else if (reg_addr == `OFS_CLOCK_LOSS_DETECT)
			reg_rdata <= clock_loss_detect_reg;
		else if (reg_addr == `OFS_SYS_CLOCK_CTRL_A)
			reg_rdata <= sys_clock_ctrl_a;
		else if (reg_addr == `OFS_SYS_CLOCK_CTRL_B)
			reg_rdata <= sys_clock_ctrl_b;
		else if (reg_addr == `OFS_SYS_CLOCK_CTRL_C)
			reg_rdata <= sys_clock_ctrl_c;
		else if (reg_addr >= `OFS_ONCHIP_OSC_CTRL_BASE
			&& reg_addr < `OFS_ONCHIP_OSC_CTRL_BASE + 8'(`NUM_ONCHIP_OSC_CTRL))
			reg_rdata <= onchip_osc_ctrl[2'(reg_addr - `OFS_ONCHIP_OSC_CTRL_BASE)];
		else if (reg_addr == `OFS_PROCESSOR_MODE_A)
			reg_rdata <= processor_mode_a;
		else if (reg_addr == `OFS_PROCESSOR_MODE_B)
			reg_rdata <= processor_mode_b;
		else if (reg_addr == `OFS_REFERENCE_CONTROL)
			reg_rdata <= reference_control;
		else if (reg_addr == `OFS_VOLTAGE_DETECT_CTRL)
			reg_rdata <= voltage_detect_ctrl;
		else if (reg_addr == `OFS_DETECT_LEVEL_SELECT)
			reg_rdata <= detect_level_select;
		else if (reg_addr == `OFS_MONITOR0_CTRL)
			reg_rdata <= monitor0_ctrl;
		else if (reg_addr == `OFS_MONITOR1_CTRL)
			reg_rdata <= monitor1_ctrl;
		else if (reg_addr == `OFS_MONITOR2_CTRL)
			reg_rdata <= monitor2_ctrl;
		else
			reg_rdata <= `RESET_BYTE;
	end

	// ------------------------------------------------------------
	// control outputs
	// ------------------------------------------------------------

	// straight views of stored bits for the clock generator
	assign fallback_to_onchip = clock_loss_detect_reg[`BIT_FALLBACK_SELECT];
	assign crystal_stopped = clock_loss_detect_reg[`BIT_CRYSTAL_STOPPED];
	assign low_speed_osc_stop = sys_clock_ctrl_b[`BIT_LOW_SPEED_STOP];
	assign periph_clock_stop_in_wait = sys_clock_ctrl_a[`BIT_PERIPH_STOP_WAIT];
	assign crystal_stop = sys_clock_ctrl_a[`BIT_CRYSTAL_STOP];
	assign stop_mode_request = sys_clock_ctrl_b[`BIT_ALL_CLOCKS_STOP];
	assign wait_request = sys_clock_ctrl_c[`BIT_WAIT_REQUEST];
	assign high_speed_osc_run = onchip_osc_ctrl[0][`BIT_HS_OSC_RUN];
	assign high_speed_select = onchip_osc_ctrl[0][`BIT_HS_SELECT];

endmodule : main_clock_loss_detect_guard

// ---- dv/main_clock_loss_detect_guard_assertions.sv ----
// concurrent checks on the ports of the clock-loss guard
module main_clock_loss_detect_guard_assertions
#(
	parameter int DETECT_WINDOW = 64,
	parameter int COUNT_WIDTH = 8
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic main_crystal_clock,
	input wire logic watchdog_event,
	input wire logic monitor1_event,
	input wire logic monitor2_event,
	input wire logic shared_irq,
	input wire logic clock_loss_source,
	input wire logic fallback_to_onchip,
	input wire logic crystal_stopped,
	input wire logic low_speed_osc_stop,
	input wire logic periph_clock_stop_in_wait,
	input wire logic crystal_stop,
	input wire logic high_speed_osc_run
);
	timeunit 1ns;
	timeprecision 100ps;
	logic prot0;
	logic last_xtal;
	logic [7:0] quiet_count;

	// ------------------------------------------------------------
	// helper state
	// ------------------------------------------------------------
	// protect bit 0 as software last wrote it
	always_ff @(posedge clock)
	begin
		if (rst)
			prot0 <= 1'b0;
		else if (reg_write && reg_addr == 8'h0A)
			prot0 <= reg_wdata[0];
	end

	// quiet cycles on the raw crystal pin; saturates so long stops do not wrap
	always_ff @(posedge clock)
	begin
		last_xtal <= main_crystal_clock;
		if (rst || main_crystal_clock != last_xtal)
			quiet_count <= 8'h00;
		else if (quiet_count != 8'hFF)
			quiet_count <= quiet_count + 8'h01;
	end

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	AST_LOSS_FLAGS: assert property ($rose(crystal_stopped) |-> fallback_to_onchip && !low_speed_osc_stop)
		else $error("loss seen without fallback or low-speed restart");
	AST_LOSS_IRQ: assert property ($rose(crystal_stopped) |-> shared_irq)
		else $error("loss seen without interrupt pulse");
	AST_LOSS_WINDOW: assert property ($rose(crystal_stopped) |-> quiet_count >= DETECT_WINDOW - 1)
		else $error("loss flagged before the quiet window ran out");
	AST_EVENT_IRQ: assert property ((watchdog_event || monitor1_event || monitor2_event) |-> ##[1:2] shared_irq)
		else $error("source event without interrupt pulse");
	AST_SOURCE_LEVEL: assert property (crystal_stopped |-> clock_loss_source)
		else $error("stopped flag set but clock loss source low");
	AST_PROTECT_B7: assert property ($past(reg_read) && $past(reg_addr) == 8'h0A |-> !reg_rdata[7])
		else $error("protect register bit 7 read as one");
	AST_CLOCK_LOCKED: assert property (reg_write && reg_addr == 8'h06 && !prot0
		|=> $stable(periph_clock_stop_in_wait) && $stable(crystal_stop))
		else $error("clock register changed while protected");
	AST_CLOCK_OPEN: assert property (reg_write && reg_addr == 8'h23 && prot0 && reg_wdata[0] |=> high_speed_osc_run)
		else $error("oscillator register ignored an enabled write");
	// read data only after a read strobe
	AST_READ_IDLE: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
		else $error("read data not zero outside its cycle");
endmodule : main_clock_loss_detect_guard_assertions

bind main_clock_loss_detect_guard main_clock_loss_detect_guard_assertions
#(.DETECT_WINDOW(DETECT_WINDOW), .COUNT_WIDTH(COUNT_WIDTH)) u_checker
(.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
	.reg_read(reg_read), .reg_rdata(reg_rdata), .main_crystal_clock(main_crystal_clock),
	.watchdog_event(watchdog_event), .monitor1_event(monitor1_event), .monitor2_event(monitor2_event),
	.shared_irq(shared_irq), .clock_loss_source(clock_loss_source), .fallback_to_onchip(fallback_to_onchip),
	.crystal_stopped(crystal_stopped), .low_speed_osc_stop(low_speed_osc_stop),
	.periph_clock_stop_in_wait(periph_clock_stop_in_wait), .crystal_stop(crystal_stop),
	.high_speed_osc_run(high_speed_osc_run));

// ---- dv/crystal_osc_model.sv ----
// behavioural model of the external main crystal oscillator
module crystal_osc_model
#(
	parameter int HALF_PERIOD = 2
)
(
	input wire logic clock,
	input wire logic run,
	output logic main_crystal_clock
);
	timeunit 1ns;
	timeprecision 100ps;
	int count = 0;

	initial main_crystal_clock = 1'b0;

	// kept far above 2 MHz
	// a dead crystal simply holds its last level: no edges is the whole symptom
	always @(posedge clock)
	begin
		if (run)
		begin
			count <= (count + 1) % HALF_PERIOD;
			if (count == HALF_PERIOD - 1)
				main_crystal_clock <= ~main_crystal_clock;
		end
	end
endmodule : crystal_osc_model

// ---- dv/main_clock_loss_detect_guard_test.sv ----
// self-checking bench for the clock-loss guard
`define CHK(name, exp, got) begin cmp_count++; if ((got) !== (exp)) begin err_count++; \
	$display("ERROR %s expected %0h seen %0h", name, (exp), (got)); end end

module main_clock_loss_detect_guard_test;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int WINDOW = 8;
	logic clock, rst, reg_write, reg_read, xtal_run, main_crystal_clock, cpu_source_crystal;
	logic watchdog_event, monitor1_event, monitor2_event, shared_irq, clock_loss_source;
	logic fallback_to_onchip, crystal_stopped, low_speed_osc_stop, periph_clock_stop_in_wait;
	logic crystal_stop, stop_mode_request, wait_request, high_speed_osc_run, high_speed_select;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	int err_count = 0;
	int cmp_count = 0;
	int irq_count = 0;

	main_clock_loss_detect_guard #(.DETECT_WINDOW(WINDOW)) DUT
	(.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .main_crystal_clock(main_crystal_clock),
		.cpu_source_crystal(cpu_source_crystal), .watchdog_event(watchdog_event),
		.monitor1_event(monitor1_event), .monitor2_event(monitor2_event), .shared_irq(shared_irq),
		.clock_loss_source(clock_loss_source), .fallback_to_onchip(fallback_to_onchip),
		.crystal_stopped(crystal_stopped), .low_speed_osc_stop(low_speed_osc_stop),
		.periph_clock_stop_in_wait(periph_clock_stop_in_wait), .crystal_stop(crystal_stop),
		.stop_mode_request(stop_mode_request), .wait_request(wait_request),
		.high_speed_osc_run(high_speed_osc_run), .high_speed_select(high_speed_select));

	crystal_osc_model u_xtal (.clock(clock), .run(xtal_run), .main_crystal_clock(main_crystal_clock));

	// ------------------------------------------------------------
	// clock, interrupt tally, watchdog
	// ------------------------------------------------------------
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// cycles with shared_irq high are counted so back-to-back requests are told apart
	always @(posedge clock)
		if (shared_irq === 1'b1)
			irq_count <= irq_count + 1;

	initial
	begin
		repeat (20000) @(posedge clock);
		err_count++;
		print_verdict();
	end

	// ------------------------------------------------------------
	// bus and helper tasks
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clock);
		reg_write <= 1'b1;
		reg_addr <= addr;
		reg_wdata <= data;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask : wr

	task automatic rd_chk(input string name, input logic [7:0] addr, input logic [7:0] mask, input logic [7:0] exp);
		@(posedge clock);
		reg_read <= 1'b1;
		reg_addr <= addr;
		@(posedge clock);
		reg_read <= 1'b0;
		#1;
		`CHK(name, exp, reg_rdata & mask)
	endtask : rd_chk

	task automatic apply_reset;
		@(posedge clock);
		rst <= 1'b1;
		repeat (6) @(posedge clock);
		rst <= 1'b0;
	endtask : apply_reset

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset_values;
		rd_chk("protect reset", 8'h0A, 8'hFF, 8'h00);
		rd_chk("detect reset", 8'h0C, 8'hFF, 8'h00);
		`CHK("outputs reset", 12'h000, {shared_irq, clock_loss_source, fallback_to_onchip, crystal_stopped,
			low_speed_osc_stop, periph_clock_stop_in_wait, crystal_stop, stop_mode_request, wait_request,
			high_speed_osc_run, high_speed_select, reg_rdata[0]})
	endtask : t_reset_values

	task automatic t_protect;
		wr(8'h0A, 8'hFF);
		rd_chk("protect b7", 8'h0A, 8'hFF, 8'h7F);
		// each group refused while only the other protect bits are set
		wr(8'h0A, 8'h0A);
		wr(8'h06, 8'hFF);
		rd_chk("clock locked", 8'h06, 8'hFF, 8'h00);
		wr(8'h0A, 8'h09);
		wr(8'h04, 8'hFF);
		rd_chk("mode locked", 8'h04, 8'hFF, 8'h00);
		wr(8'h38, 8'h5A);
		rd_chk("voltage open", 8'h38, 8'hFF, 8'h5A);
		wr(8'h0A, 8'h03);
		wr(8'h31, 8'hFF);
		rd_chk("voltage locked", 8'h31, 8'hFF, 8'h00);
		wr(8'h05, 8'hA5);
		rd_chk("mode open", 8'h05, 8'hFF, 8'hA5);
		wr(8'h0A, 8'h01);
		wr(8'h06, 8'h24);
		wr(8'h07, 8'h11);
		wr(8'h08, 8'h01);
		wr(8'h23, 8'h03);
		@(negedge clock);
		`CHK("clock bits", 7'h7F, {periph_clock_stop_in_wait, crystal_stop, stop_mode_request,
			low_speed_osc_stop, wait_request, high_speed_osc_run, high_speed_select})
		rd_chk("protect kept", 8'h0A, 8'hFF, 8'h01);
		wr(8'h06, 8'h00);
		wr(8'h08, 8'h00);
		wr(8'h23, 8'h00);
		wr(8'h07, 8'h10);
		wr(8'h50, 8'hFF);
		rd_chk("unmapped", 8'h50, 8'hFF, 8'h00);
	endtask : t_protect

	task automatic t_loss;
		int n;
		int i;
		cpu_source_crystal <= 1'b1;
		wr(8'h0C, 8'h03);
		repeat (4 * WINDOW) @(posedge clock);
		`CHK("no false loss", 1'b0, crystal_stopped)
		n = irq_count;
		xtal_run <= 1'b0;
		for (i = 0; i < 5 * WINDOW && crystal_stopped !== 1'b1; i++)
			@(posedge clock);
		@(negedge clock);
		`CHK("loss flags", 3'b110, {fallback_to_onchip, crystal_stopped, low_speed_osc_stop})
		repeat (2) @(posedge clock);
		#1;
		`CHK("loss irq", n + 1, irq_count)
		rd_chk("detect reg", 8'h0C, 8'h0F, 8'h0F);
		@(posedge clock);
		xtal_run <= 1'b1;
		repeat (4 * WINDOW) @(posedge clock);
		`CHK("armed fallback source", 2'b01, {crystal_stopped, clock_loss_source})
		`CHK("no switch back", 1'b1, fallback_to_onchip)
		wr(8'h0C, 8'h00);
		@(negedge clock);
		`CHK("source cleared", 2'b00, {fallback_to_onchip, clock_loss_source})
	endtask : t_loss

	task automatic t_unarmed;
		for (int k = 0; k < 4; k++)
		begin
			wr(8'h0C, (k < 3) ? 8'(k) : 8'h03);
			cpu_source_crystal <= (k != 3);
			@(posedge clock);
			xtal_run <= 1'b0;
			repeat (5 * WINDOW) @(posedge clock);
			`CHK("no detect", 2'b00, {crystal_stopped, fallback_to_onchip})
			xtal_run <= 1'b1;
			repeat (WINDOW) @(posedge clock);
		end
		wr(8'h0C, 8'h00);
	endtask : t_unarmed

	task automatic t_events;
		int n;
		n = irq_count;
		@(posedge clock);
		watchdog_event <= 1'b1;
		@(posedge clock);
		watchdog_event <= 1'b0;
		monitor1_event <= 1'b1;
		@(posedge clock);
		monitor1_event <= 1'b0;
		monitor2_event <= 1'b1;
		@(posedge clock);
		monitor2_event <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
		`CHK("shared irq count", n + 3, irq_count)
		rd_chk("watchdog and mon2 flags", 8'h3A, 8'h0C, 8'h0C);
		rd_chk("mon1 flag", 8'h39, 8'h04, 8'h04);
		`CHK("not clock loss", 1'b0, clock_loss_source)
	endtask : t_events

	task automatic print_verdict;
		if (err_count == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : print_verdict

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		rst = 1'b1;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		xtal_run = 1'b1;
		cpu_source_crystal = 1'b0;
		watchdog_event = 1'b0;
		monitor1_event = 1'b0;
		monitor2_event = 1'b0;
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		t_reset_values();
		t_protect();
		t_loss();
		t_unarmed();
		t_events();
		// a second reset mid-run must bring the protect and detect registers and the outputs back
		apply_reset();
		t_reset_values();
		print_verdict();
	end
endmodule : main_clock_loss_detect_guard_test
